// *** logic/acr_config_regs.sv ***
// amplifier configuration register bank behind an i2c slave, with decoded settings
`timescale 1ns/1ps
module acr_config_regs
    import acr_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = ACR_DEV_ADDR
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic frame_sync_i,
    output logic highpass_off_o,
    output logic [7:0] thermal_warn_celsius_o,
    output logic overcurrent_level_sel_o,
    output logic volume_step_o,
    output logic [1:0] gain_sel_o,
    output logic [5:0] pwm_multiple_o,
    output logic [7:0] modulator_oversample_o,
    output logic [5:0] phase_offset_deg_o,
    output logic [1:0] sample_rate_sel_o,
    output logic slot_half_sel_o,
    output logic slot_width_16_o,
    output logic pair_swap_o,
    output logic [2:0] format_sel_o,
    output logic [11:0] ch_slot_o,
    output logic config_unsupported_o
);
    typedef struct packed {
        acr_i2c_st_t st;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic [7:0] sub;
        logic rw;
        logic nack;
        logic scl_q;
        logic sda_q;
        logic sda_oe;
        logic [7:0] prot;
        logic [7:0] sw;
        logic [7:0] ap;
        logic [2:0] fs_cnt;
        logic vol_step;
        logic hpf_off;
        logic [7:0] otw_c;
        logic oc_sel;
        logic [1:0] gain;
        logic [5:0] pwm_mul;
        logic [7:0] osr;
        logic [5:0] phase;
        logic [1:0] rate;
        logic half;
        logic width16;
        logic swap;
        logic [2:0] fmt;
        logic [11:0] slots;
        logic unsup;
    } acr_state_t;

    acr_state_t q;
    acr_state_t next_q;
    logic [1:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    acr_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .async_i({scl_i, sda_i}),
        .sync_o(pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];
    assign scl_rise = scl_s & ~q.scl_q;
    assign scl_fall = ~scl_s & q.scl_q;
    assign start_cond = scl_s & q.scl_q & q.sda_q & ~sda_s;
    assign stop_cond = scl_s & q.scl_q & ~q.sda_q & sda_s;

    // unmapped subaddresses read as zero
    function automatic logic [7:0] reg_read(input acr_state_t s, input logic [7:0] a);
        logic [7:0] d;
        unique case (a)
            ADDR_PROT: d = s.prot;
            ADDR_SW: d = s.sw;
            ADDR_AP: d = s.ap;
            default: d = 8'h00;
        endcase
        return d;
    endfunction : reg_read

    function automatic logic [5:0] pwm_decode(input logic [2:0] code);
        logic [5:0] m;
        m = 6'h00;
        unique case (code)
            3'h0: m = 6'h08;
            3'h1: m = 6'h0A;
            3'h5: m = 6'h26;
            3'h6: m = 6'h2C;
            3'h7: m = 6'h30;
            default: m = 6'h00;
        endcase
        return m;
    endfunction : pwm_decode

    function automatic logic [5:0] phase_decode(input logic [1:0] code);
        logic [5:0] p;
        p = 6'h00;
        unique case (code)
            2'h0: p = 6'h00;
            2'h1: p = 6'h1E;
            2'h2: p = 6'h2D;
            2'h3: p = 6'h3C;
        endcase
        return p;
    endfunction : phase_decode

    function automatic logic [2:0] slot_of(input logic [1:0] ch, input logic half, input logic swap);
        logic [1:0] idx;
        idx = swap ? (ch ^ 2'h2) : ch;
        return {half, idx};
    endfunction : slot_of

    always_comb begin
        logic [2:0] ramp_lim;
        logic [7:0] rd;
        ramp_lim = 3'h0;
        rd = 8'h00;
        next_q = q;
        next_q.scl_q = scl_s;
        next_q.sda_q = sda_s;
        next_q.vol_step = 1'b0;

        if (start_cond) begin
            next_q.st = ST_ADDR;
            next_q.cnt = 4'h0;
            next_q.sda_oe = 1'b0;
        end else if (stop_cond) begin
            next_q.st = ST_IDLE;
            next_q.sda_oe = 1'b0;
        end else begin
            unique case (q.st)
                ST_IDLE, ST_WAIT_STOP: begin
                    next_q.sda_oe = 1'b0;
                end
                ST_ADDR, ST_SUB, ST_WDATA: begin
                    if (scl_rise && q.cnt != BITS_PER_BYTE) begin
                        next_q.shreg = {q.shreg[6:0], sda_s};
                        next_q.cnt = q.cnt + 4'h1;
                    end else if (scl_fall && q.cnt == BITS_PER_BYTE) begin
                        next_q.sda_oe = 1'b1;
                        if (q.st == ST_ADDR) begin
                            if (q.shreg[7:1] == DEV_ADDR) begin
                                next_q.rw = q.shreg[0];
                                next_q.st = ST_ADDR_ACK;
                            end else begin
                                next_q.sda_oe = 1'b0;
                                next_q.st = ST_WAIT_STOP;
                            end
                        end else if (q.st == ST_SUB) begin
                            next_q.sub = q.shreg;
                            next_q.st = ST_SUB_ACK;
                        end else begin
                            // ack every data byte and step the subaddress on
                            next_q.st = ST_WDATA_ACK;
                            next_q.sub = q.sub + 8'h01;
                            unique case (q.sub)
                                ADDR_PROT: next_q.prot = q.shreg;
                                ADDR_SW: next_q.sw = q.shreg & SW_WMASK;
                                ADDR_AP: next_q.ap = q.shreg;
                                default: next_q.prot = q.prot;
                            endcase
                        end
                    end
                end
                ST_SUB_ACK, ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        next_q.sda_oe = 1'b0;
                        next_q.cnt = 4'h0;
                        next_q.st = (q.st == ST_SUB_ACK) ? ST_WDATA : ST_WDATA;
                    end
                end
                ST_ADDR_ACK, ST_RDATA_ACK: begin
                    if (scl_rise && q.st == ST_RDATA_ACK) begin
                        next_q.nack = sda_s;
                    end
                    if (scl_fall) begin
                        if (q.st == ST_ADDR_ACK && !q.rw) begin
                            next_q.sda_oe = 1'b0;
                            next_q.cnt = 4'h0;
                            next_q.st = ST_SUB;
                        end else if (q.st == ST_RDATA_ACK && q.nack) begin
                            next_q.sda_oe = 1'b0;
                            next_q.st = ST_WAIT_STOP;
                        end else begin
                            // open drain: pull low only for a zero bit
                            rd = reg_read(q, q.sub);
                            next_q.shreg = rd;
                            next_q.sda_oe = ~rd[7];
                            next_q.cnt = 4'h1;
                            next_q.sub = q.sub + 8'h01;
                            next_q.st = ST_RDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (q.cnt == BITS_PER_BYTE) begin
                            next_q.sda_oe = 1'b0;
                            next_q.nack = 1'b0;
                            next_q.st = ST_RDATA_ACK;
                        end else begin
                            next_q.shreg = {q.shreg[6:0], 1'b0};
                            next_q.sda_oe = ~q.shreg[6];
                            next_q.cnt = q.cnt + 4'h1;
                        end
                    end
                end
                default: begin
                    next_q.st = ST_IDLE;
                    next_q.sda_oe = 1'b0;
                end
            endcase
        end

        // one volume step per 1, 2, 4 or 8 frame syncs
        ramp_lim = 3'((4'h1 << q.prot[PG_RAMP_LSB +: 2]) - 4'h1);
        if (frame_sync_i) begin
            if (q.fs_cnt >= ramp_lim) begin
                next_q.fs_cnt = FS_CNT_RST;
                next_q.vol_step = 1'b1;
            end else begin
                next_q.fs_cnt = q.fs_cnt + 3'h1;
            end
        end

        next_q.hpf_off = q.prot[PG_HPF_BIT];
        next_q.otw_c = 8'h8C - 8'(q.prot[PG_OTW_LSB +: 2]) * 8'h0A;
        next_q.oc_sel = q.prot[PG_OC_BIT];
        next_q.gain = q.prot[PG_GAIN_LSB +: 2];
        next_q.pwm_mul = pwm_decode(q.sw[SW_PWM_LSB +: 3]);
        next_q.osr = q.sw[SW_OSR_BIT] ? 8'h80 : 8'h40;
        next_q.phase = phase_decode(q.sw[SW_PHASE_LSB +: 2]);
        next_q.rate = q.ap[AP_RATE_LSB +: 2];
        next_q.half = q.ap[AP_HALF_BIT];
        next_q.width16 = q.ap[AP_SIZE_BIT];
        next_q.swap = q.ap[AP_SWAP_BIT];
        next_q.fmt = q.ap[AP_FMT_LSB +: 3];
        for (int c = 0; c < 4; c++) begin
            next_q.slots[c*3 +: 3] = slot_of(2'(c), q.ap[AP_HALF_BIT], q.ap[AP_SWAP_BIT]);
        end
        // flags what the host should never program; the bank still stores it
        next_q.unsup = ((q.sw[SW_PWM_LSB +: 3] == PWM_48X) &&
                        (q.ap[AP_RATE_LSB +: 2] == RATE_48K || q.ap[AP_RATE_LSB +: 2] == RATE_96K)) ||
                       (pwm_decode(q.sw[SW_PWM_LSB +: 3]) == 6'h00) ||
                       (q.ap[AP_RATE_LSB +: 2] == RATE_RSVD) ||
                       (q.ap[AP_FMT_LSB +: 3] == FMT_RSVD);

        if (!reset_n_i) begin
            next_q = '0;
            next_q.st = ST_IDLE;
            next_q.scl_q = 1'b1;
            next_q.sda_q = 1'b1;
            next_q.prot = RST_PROT;
            next_q.sw = RST_SW;
            next_q.ap = RST_AP;
            next_q.fs_cnt = FS_CNT_RST;
            next_q.osr = RST_OSR;
            next_q.otw_c = RST_OTW_C;
            next_q.oc_sel = RST_OC;
            next_q.gain = RST_GAIN;
            next_q.pwm_mul = RST_PWM_MUL;
            next_q.phase = RST_PHASE;
            next_q.fmt = RST_FMT;
            next_q.slots = RST_SLOTS;
        end
    end

    always_ff @(posedge core_clk_i) begin
        q <= next_q;
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = q.sda_oe;
    assign highpass_off_o = q.hpf_off;
    assign thermal_warn_celsius_o = q.otw_c;
    assign overcurrent_level_sel_o = q.oc_sel;
    assign volume_step_o = q.vol_step;
    assign gain_sel_o = q.gain;
    assign pwm_multiple_o = q.pwm_mul;
    assign modulator_oversample_o = q.osr;
    assign phase_offset_deg_o = q.phase;
    assign sample_rate_sel_o = q.rate;
    assign slot_half_sel_o = q.half;
    assign slot_width_16_o = q.width16;
    assign pair_swap_o = q.swap;
    assign format_sel_o = q.fmt;
    assign ch_slot_o = q.slots;
    assign config_unsupported_o = q.unsup;

    default clocking acr_cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    chk_hpf_follow: assert property (highpass_off_o == $past(q.prot[PG_HPF_BIT]))
        else $error("high-pass bypass output does not follow its bit");
    chk_otw_level: assert property (($past(q.prot[6:5]) == 2'h3) |-> (thermal_warn_celsius_o == 8'h6E))
        else $error("thermal warning code 11 does not give 110 C");
    chk_reset_values: assert property ($past(!reset_n_i) |->
        {q.prot, q.sw, q.ap} == {RST_PROT, RST_SW, RST_AP})
        else $error("register reset values wrong");
    chk_ramp_slow: assert property ((frame_sync_i && &q.prot[3:2] && q.fs_cnt != 3'h7) |=> !volume_step_o)
        else $error("volume step came before eight frame syncs");
    chk_ramp_fast: assert property ((frame_sync_i && q.prot[3:2] == 2'h0) |=> volume_step_o)
        else $error("volume step missing at rate one per frame sync");
    chk_pwm_reserved: assert property (($past(q.sw[6:4]) inside {[3'h2:3'h4]}) |-> pwm_multiple_o == 6'h00)
        else $error("reserved switching code gives a multiple");
    chk_sw_rsvd_bits: assert property (q.sw[7] == 1'b0 && q.sw[3] == 1'b0)
        else $error("reserved switching bits not zero");
    chk_osr_select: assert property (($past(q.sw[2]) == 1'b1) |-> modulator_oversample_o == 8'h80)
        else $error("oversample bit 1 does not give 128x");
    chk_phase_offset: assert property (($past(q.sw[1:0]) == 2'h1) |-> phase_offset_deg_o == 6'h1E)
        else $error("phase code 01 does not give 30 degrees");
    chk_ch1_slot: assert property (ch_slot_o[2:0] == {$past(q.ap[5]), $past(q.ap[3]), 1'b0})
        else $error("channel 1 slot map wrong");
    chk_wr_ack_inc: assert property ((q.st == ST_WDATA && scl_fall && q.cnt == 4'h8) |=>
        (sda_oe_o && q.sub == $past(q.sub) + 8'h01))
        else $error("data byte not acked or subaddress not advanced");
endmodule : acr_config_regs

// *** inc/acr_pkg.sv ***
// package with register map, field layout, reset values and i2c states for the amplifier config bank
// Notes on behaviour
// - highpass_off bit 7 of protection_gain_config disables the input high-pass filter; resets 0.
// - thermal_warn_threshold bits 6-5 pick 140/130/120/110 C warning; resets to 01.
// - overcurrent_level_sel bit 4 picks level 1 at 0, level 2 at 1; resets 1.
// - volume ramp bits 3-2 give one volume step per 1, 2, 4 or 8 frame syncs.
// - gain bits 1-0 pick 7.5, 15, 21 or 29 V peak output; resets 10.
// - switching rate bits 6-4 give 8x,10x,38x,44x,48x; 010-100 reserved; resets 110.
// - modulator_oversample_sel bit 2 gives 64x at 0, 128x at 1; resets 0.
// - output phase bits 1-0 give 0, 30, 45 or 60 degree offset; resets 10.
// - sample_rate_sel bits 7-6 declare 44.1, 48 or 96 kHz; 11 reserved; resets 00.
// - slot_half_sel takes channels from first four TDM slots at 0, last four at 1.
// - slot width bit treats slots as 24/32-bit at 0 and 16-bit at 1.
// - pair swap bit exchanges slot mapping of channels 1/2 with channels 3/4.
// - format bits 2-0 pick RJ24/20/18/16, I2S, LJ, DSP; 111 reserved; resets 100.
// - protection_gain_config at 0x01 resets 0x32; switching at 0x02, audio port at 0x03.
// - multi-byte writes ack every data byte and advance the subaddress by one.
package acr_pkg;
    localparam logic [6:0] ACR_DEV_ADDR = 7'h6A;
    localparam logic [7:0] ADDR_PROT = 8'h01;
    localparam logic [7:0] ADDR_SW = 8'h02;
    localparam logic [7:0] ADDR_AP = 8'h03;
    localparam logic [7:0] RST_PROT = 8'h32;
    localparam logic [7:0] RST_SW = 8'h62;
    localparam logic [7:0] RST_AP = 8'h04;
    // decoded settings that the reset register values give
    localparam logic [7:0] RST_OTW_C = 8'h82;
    localparam logic [7:0] RST_OSR = 8'h40;
    localparam logic RST_OC = 1'b1;
    localparam logic [1:0] RST_GAIN = 2'h2;
    localparam logic [5:0] RST_PWM_MUL = 6'h2C;
    localparam logic [5:0] RST_PHASE = 6'h2D;
    localparam logic [2:0] RST_FMT = 3'h4;
    localparam logic [11:0] RST_SLOTS = 12'h688;
    // reserved bits 7 and 3 of the switching register hold zero
    localparam logic [7:0] SW_WMASK = 8'h77;
    localparam int PG_HPF_BIT = 7;
    localparam int PG_OTW_LSB = 5;
    localparam int PG_OC_BIT = 4;
    localparam int PG_RAMP_LSB = 2;
    localparam int PG_GAIN_LSB = 0;
    localparam int SW_PWM_LSB = 4;
    localparam int SW_OSR_BIT = 2;
    localparam int SW_PHASE_LSB = 0;
    localparam int AP_RATE_LSB = 6;
    localparam int AP_HALF_BIT = 5;
    localparam int AP_SIZE_BIT = 4;
    localparam int AP_SWAP_BIT = 3;
    localparam int AP_FMT_LSB = 0;
    localparam logic [1:0] RATE_48K = 2'h1;
    localparam logic [1:0] RATE_96K = 2'h2;
    localparam logic [1:0] RATE_RSVD = 2'h3;
    localparam logic [2:0] PWM_48X = 3'h7;
    localparam logic [2:0] FMT_RSVD = 3'h7;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [2:0] FS_CNT_RST = 3'h0;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_ADDR_ACK = 4'b0010,
        ST_SUB = 4'b0011,
        ST_SUB_ACK = 4'b0100,
        ST_WDATA = 4'b0101,
        ST_WDATA_ACK = 4'b0110,
        ST_RDATA = 4'b0111,
        ST_RDATA_ACK = 4'b1000,
        ST_WAIT_STOP = 4'b1001
    } acr_i2c_st_t;
endpackage : acr_pkg

// *** logic/acr_sync.sv ***
// two-flop synchroniser for the i2c pins
`timescale 1ns/1ps
module acr_sync
    import acr_pkg::*;
#(
    parameter int WIDTH = 2
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } acr_sync_state_t;

    acr_sync_state_t q;
    acr_sync_state_t next_q;

    // idle i2c lines are high, so reset to ones to avoid a false start
    always_comb begin
        next_q = q;
        next_q.meta = async_i;
        next_q.stable = q.meta;
        if (!reset_n_i) begin
            next_q.meta = '1;
            next_q.stable = '1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        q <= next_q;
    end

    assign sync_o = q.stable;
endmodule : acr_sync

// *** tb/acr_i2c_host.sv ***
// behavioural i2c host that configures the register bank over scl and an open-drain sda
`timescale 1ns/1ps
module acr_i2c_host (
    input wire logic core_clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    // half is the scl high time in core clocks; the bench raises it to play a slow host
    int half = 8;

    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : tick

    // also serves as repeated start: sda is released while scl is still low
    task automatic start_cond();
        tick(2);
        sda_oe_o <= 1'b0;
        tick(half);
        scl_o <= 1'b1;
        tick(half);
        sda_oe_o <= 1'b1;
        tick(half);
        scl_o <= 1'b0;
        tick(2);
    endtask : start_cond

    // data moves two clocks after scl falls and is sampled mid-way through scl high
    task automatic bit_io(input logic b, output logic seen);
        sda_oe_o <= ~b;
        tick(half);
        scl_o <= 1'b1;
        tick(half / 2);
        seen = sda_i;
        tick(half - half / 2);
        scl_o <= 1'b0;
        tick(2);
    endtask : bit_io

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask : send_byte

    task automatic recv_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(~ack, s);
    endtask : recv_byte

    task automatic stop_cond();
        sda_oe_o <= 1'b1;
        tick(half);
        scl_o <= 1'b1;
        tick(half);
        sda_oe_o <= 1'b0;
        tick(half);
    endtask : stop_cond
endmodule : acr_i2c_host

// *** tb/amp_config_registers_bench.sv ***
// self-checking bench for the amplifier configuration register bank
`timescale 1ns/1ps
module amp_config_registers_bench
    import acr_pkg::*;
;
    logic clk, rst_n, scl, host_oe, fs, sda_out, sda_oe, hp_off, oc_sel, vstep, half_sel, w16, swap, unsup, ack;
    logic [7:0] otw, osr, p, s, a;
    logic [1:0] gain, rate;
    logic [5:0] pwm, phase;
    logic [2:0] fmt, c;
    logic [11:0] slots;
    logic [23:0] q;
    wire sda_line;
    int fails = 0, num_checks = 0, steps = 0, base;
    integer seed = 32'h0F8B;

    // open drain with pull-up: low whenever either party pulls
    assign sda_line = (sda_oe ? sda_out : 1'b1) & ~host_oe;

    acr_config_regs DUT (.core_clk_i(clk), .reset_n_i(rst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_out),
        .sda_oe_o(sda_oe), .frame_sync_i(fs), .highpass_off_o(hp_off), .thermal_warn_celsius_o(otw),
        .overcurrent_level_sel_o(oc_sel), .volume_step_o(vstep), .gain_sel_o(gain), .pwm_multiple_o(pwm),
        .modulator_oversample_o(osr), .phase_offset_deg_o(phase), .sample_rate_sel_o(rate),
        .slot_half_sel_o(half_sel), .slot_width_16_o(w16), .pair_swap_o(swap), .format_sel_o(fmt),
        .ch_slot_o(slots), .config_unsupported_o(unsup));

    acr_i2c_host host (.core_clk_i(clk), .sda_i(sda_line), .scl_o(scl), .sda_oe_o(host_oe));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) if (vstep === 1'b1) steps <= steps + 1;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    function automatic int exp_pwm(input logic [2:0] k);
        case (k)
            3'h0: return 8;
            3'h1: return 10;
            3'h5: return 38;
            3'h6: return 44;
            3'h7: return 48;
            default: return 0;
        endcase
    endfunction : exp_pwm

    function automatic int exp_phase(input logic [1:0] k);
        case (k)
            2'h0: return 0;
            2'h1: return 30;
            2'h2: return 45;
            default: return 60;
        endcase
    endfunction : exp_phase

    function automatic logic [11:0] exp_slots(input logic [7:0] ap);
        logic [11:0] r;
        for (int ch = 0; ch < 4; ch++) r[ch * 3 +: 3] = {ap[5], ap[3] ? 2'(ch ^ 2) : 2'(ch)};
        return r;
    endfunction : exp_slots

    function automatic logic exp_unsup(input logic [7:0] sw, input logic [7:0] ap);
        return (sw[6:4] == 3'h7 && (ap[7:6] == 2'h1 || ap[7:6] == 2'h2)) || (sw[6:4] inside {[3'h2:3'h4]})
            || ap[7:6] == 2'h3 || ap[2:0] == 3'h7;
    endfunction : exp_unsup

    task automatic wr(input logic [7:0] sub, input logic [23:0] d, input int n);
        host.start_cond();
        host.send_byte({ACR_DEV_ADDR, 1'b0}, ack);
        check(ack, 1'b1);
        host.send_byte(sub, ack);
        check(ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            host.send_byte(d[i * 8 +: 8], ack);
            check(ack, 1'b1);
        end
        host.stop_cond();
    endtask : wr

    task automatic rd(input logic [7:0] sub, input int n, output logic [23:0] r);
        logic [7:0] b;
        r = '0;
        host.start_cond();
        host.send_byte({ACR_DEV_ADDR, 1'b0}, ack);
        host.send_byte(sub, ack);
        host.start_cond();
        host.send_byte({ACR_DEV_ADDR, 1'b1}, ack);
        check(ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            host.recv_byte(i < n - 1, b);
            r[i * 8 +: 8] = b;
        end
        host.stop_cond();
    endtask : rd

    task automatic check_all();
        check(hp_off, p[7]);
        check(otw, 140 - 10 * p[6:5]);
        check(oc_sel, p[4]);
        check(gain, p[1:0]);
        check(pwm, exp_pwm(s[6:4]));
        check(osr, s[2] ? 128 : 64);
        check(phase, exp_phase(s[1:0]));
        check(rate, a[7:6]);
        check(half_sel, a[5]);
        check(w16, a[4]);
        check(swap, a[3]);
        check(slots, exp_slots(a));
        check(fmt, a[2:0]);
        check(unsup, exp_unsup(s, a));
        rd(ADDR_PROT, 3, q);
        check(q, {a, s, p});
    endtask : check_all

    task automatic finish_test();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    initial begin
        repeat (90000) @(posedge clk);
        fails++;
        finish_test();
    end

    initial begin
        rst_n = 1'b0;
        fs = 1'b0;
        p = 8'h32;
        s = 8'h62;
        a = 8'h04;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        host.tick(5);
        check(sda_oe, 1'b0);
        check(vstep, 1'b0);
        check_all();
        // every code of every field, reserved ones included, to exercise decode and the unsupported flag
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            p = {c[0], c[1:0], c[2], c[1:0], c[1:0]};
            s = {1'b0, c, 1'b0, c[0], c[1:0]};
            a = {c[1:0], c[2], c[0], c[1], c};
            wr(ADDR_PROT, {a, s, p}, 3);
            check_all();
        end
        for (int k = 0; k < 6; k++) begin
            host.half = (k == 2) ? 20 : 8;
            p = 8'($random(seed));
            s = 8'($random(seed)) & 8'h77;
            a = 8'($random(seed));
            if (s[6:4] inside {[3'h2:3'h4]}) s[6:4] = 3'h6;
            if (a[7:6] == RATE_RSVD) a[7:6] = 2'h0;
            if (a[2:0] == FMT_RSVD) a[2:0] = 3'h4;
            if (s[6:4] == PWM_48X && a[7:6] != 2'h0) s[6:4] = 3'h5;
            wr(ADDR_PROT, {a, s, p}, 3);
            check_all();
        end
        host.half = 8;
        // reserved switching bits refused, 48x with 48 kHz flagged
        wr(ADDR_SW, 24'hFF, 1);
        wr(ADDR_AP, 24'h47, 1);
        s = 8'h77;
        a = 8'h47;
        check_all();
        // second byte runs past the bank and must be dropped
        wr(ADDR_AP, {8'h00, 8'hA5, 8'h04}, 2);
        a = 8'h04;
        rd(8'h04, 1, q);
        check(q[7:0], 8'h00);
        check_all();
        host.start_cond();
        host.send_byte({ACR_DEV_ADDR ^ 7'h01, 1'b0}, ack);
        check(ack, 1'b0);
        host.send_byte(ADDR_PROT, ack);
        host.send_byte(8'h00, ack);
        host.stop_cond();
        check_all();
        // ascending codes so a leftover frame count can never exceed the new divide
        for (int r = 0; r < 4; r++) begin
            p[3:2] = 2'(r);
            wr(ADDR_PROT, {16'h0, p}, 1);
            base = steps;
            repeat (16) @(posedge clk) fs <= 1'b1;
            @(posedge clk) fs <= 1'b0;
            host.tick(4);
            check(steps - base, 16 >> r);
        end
        finish_test();
    end
endmodule : amp_config_registers_bench
